/* src/image_block_transfer_queue.sv */
// Purpose: Queue of finished image blocks and its send control toward the stream channel.
// Assumes: Block words arrive synchronous to ref_clk and cannot be stalled.
// Notes: APB slave with zero wait states; stream output through a two-entry buffer.
//
// What this block does
// - Automatic policies start sending once one link packet of words is buffered.
// - Manual policy sends blocks only on host command, per selected submode.
// - Continuous submode streams back to back between start and stop.
// - Multi-block submode sends exactly the programmed block count, then stops.
// - Burst count is used only in multi-block submode.
// - Queue capacity in blocks is readable.
// - Current queue occupancy in blocks is readable.
// - Count of blocks discarded by overflow is readable.
// - Writable queue order selector; oldest-first is its only legal value.
// - Start command, manual policy only, begins streaming queued blocks.
// - Stop command finishes the block in progress, then streaming ceases.
// - Full queue: newest block replaces oldest unsent block, lost tally increments.
// - Oldest queued block is always sent next.
// - Closing the stream channel empties the queue and cancels pending sends.
`timescale 1ns/1ps
module image_block_transfer_queue #(
  parameter int DATA_W = 32,
  parameter int QUEUE_BLOCKS = 4,
  parameter int BLOCK_WORDS = 16,
  parameter int PACKET_WORDS = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic inValid,
  input wire logic [DATA_W-1:0] inData,
  input wire logic inLast,
  output logic outValid,
  input wire logic outReady,
  output logic [DATA_W-1:0] outData,
  output logic outLast
);
  localparam int SLOTS = QUEUE_BLOCKS + 2;
  localparam int SW = $clog2(SLOTS);
  localparam int WW = $clog2(BLOCK_WORDS + 1);
  localparam int QW = $clog2(QUEUE_BLOCKS + 1);
  localparam int HW = (QUEUE_BLOCKS > 1) ? $clog2(QUEUE_BLOCKS) : 1;
  localparam int MW = $clog2(SLOTS * BLOCK_WORDS);

  if (QUEUE_BLOCKS < 1 || BLOCK_WORDS < 1 || PACKET_WORDS < 1 ||
      PACKET_WORDS > BLOCK_WORDS || DATA_W < 1) begin
    $error("image_block_transfer_queue: unsupported parameter values");
  end

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus.

  logic [1:0] policy, next_policy;
  logic submode, next_submode;
  logic [31:0] burstTotal, next_burstTotal;
  logic [31:0] next_prdata;
  logic cmdGo, cmdHalt, cmdFlush;
  logic mapped, wrAccess;
  logic [QW-1:0] cnt, next_cnt;
  logic [31:0] lost, next_lost;
  logic streaming, next_streaming;
  tx_state_e txState, next_txState;

  assign pready = 1'b1;
  assign mapped = paddr == transfer_queue_pkg::CTRL_OFS || paddr == transfer_queue_pkg::BURST_OFS
    || paddr == transfer_queue_pkg::CAP_OFS || paddr == transfer_queue_pkg::OCC_OFS
    || paddr == transfer_queue_pkg::LOST_OFS || paddr == transfer_queue_pkg::CMD_OFS
    || paddr == transfer_queue_pkg::STAT_OFS;
  assign pslverr = psel && penable && !mapped;
  assign wrAccess = psel && penable && pwrite;
  assign cmdGo = wrAccess && paddr == transfer_queue_pkg::CMD_OFS
    && pwdata[transfer_queue_pkg::CMD_GO_BIT];
  assign cmdHalt = wrAccess && paddr == transfer_queue_pkg::CMD_OFS
    && pwdata[transfer_queue_pkg::CMD_HALT_BIT];
  assign cmdFlush = wrAccess && paddr == transfer_queue_pkg::CMD_OFS
    && pwdata[transfer_queue_pkg::CMD_FLUSH_BIT];

  always_comb begin
    next_policy = policy;
    next_submode = submode;
    next_burstTotal = burstTotal;
    next_prdata = prdata;
    if (wrAccess && paddr == transfer_queue_pkg::CTRL_OFS) begin
      // Illegal policy codes and any order other than oldest-first are ignored.
      if (pwdata[transfer_queue_pkg::POLICY_LSB +: transfer_queue_pkg::POLICY_W]
          <= transfer_queue_pkg::POLICY_MANUAL) begin
        next_policy = pwdata[transfer_queue_pkg::POLICY_LSB +: transfer_queue_pkg::POLICY_W];
      end
      next_submode = pwdata[transfer_queue_pkg::SUBMODE_BIT];
    end
    if (wrAccess && paddr == transfer_queue_pkg::BURST_OFS) begin
      next_burstTotal = pwdata;
    end
    if (psel && !penable) begin
      next_prdata = '0;
      unique case (paddr)
        transfer_queue_pkg::CTRL_OFS: begin
          next_prdata[transfer_queue_pkg::POLICY_LSB +: transfer_queue_pkg::POLICY_W] = policy;
          next_prdata[transfer_queue_pkg::SUBMODE_BIT] = submode;
          next_prdata[transfer_queue_pkg::ORDER_BIT] = transfer_queue_pkg::ORDER_OLDEST_FIRST;
        end
        transfer_queue_pkg::BURST_OFS: next_prdata = burstTotal;
        transfer_queue_pkg::CAP_OFS: next_prdata = 32'(QUEUE_BLOCKS);
        transfer_queue_pkg::OCC_OFS: next_prdata = 32'(cnt);
        transfer_queue_pkg::LOST_OFS: next_prdata = lost;
        transfer_queue_pkg::STAT_OFS: begin
          next_prdata[transfer_queue_pkg::STAT_STREAM_BIT] = streaming;
          next_prdata[transfer_queue_pkg::STAT_SENDING_BIT] = txState == TX_SEND;
        end
        default: next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      policy <= transfer_queue_pkg::POLICY_RESET;
      submode <= transfer_queue_pkg::SUBMODE_RESET;
      burstTotal <= transfer_queue_pkg::BURST_RESET;
      prdata <= '0;
    end else begin
      policy <= next_policy;
      submode <= next_submode;
      burstTotal <= next_burstTotal;
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Block store, queue and send control.

  logic [DATA_W-1:0] mem [SLOTS*BLOCK_WORDS];
  logic [WW-1:0] slotLen [SLOTS];
  logic [SW-1:0] ring [QUEUE_BLOCKS];
  logic [SW-1:0] next_ring [QUEUE_BLOCKS];
  logic [HW-1:0] head, next_head;
  logic [SLOTS-1:0] used, next_used;
  logic [SW-1:0] wrId, next_wrId, txId, next_txId, freeId, curId;
  logic [WW-1:0] wrCount, next_wrCount, txIdx, next_txIdx, curIdx, avail;
  logic wrOpen, next_wrOpen, wrCut, next_wrCut;
  logic [31:0] burstLeft, next_burstLeft;
  logic manual, multi, allowed, cutOk, memWr, txPush, txLast, startBlock, bufSpace;
  logic [DATA_W-1:0] txData;

  function automatic logic [HW-1:0] stepIdx(input logic [HW-1:0] h);
    return (32'(h) == QUEUE_BLOCKS - 1) ? '0 : HW'(h + 1'b1);
  endfunction

  function automatic logic [HW-1:0] addIdx(input logic [HW-1:0] h, input logic [QW-1:0] n);
    int t;
    t = 32'(h) + 32'(n);
    if (t >= QUEUE_BLOCKS) begin
      t = t - QUEUE_BLOCKS;
    end
    return HW'(t);
  endfunction

  always_comb begin
    freeId = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (!used[i]) begin
        freeId = SW'(i);
      end
    end
  end

  assign manual = policy == transfer_queue_pkg::POLICY_MANUAL;
  assign multi = manual && submode == transfer_queue_pkg::SUBMODE_MULTI;
  assign allowed = !manual || streaming;
  assign cutOk = wrOpen && !wrCut && 32'(wrCount) >= PACKET_WORDS && !(inValid && inLast);
  assign curId = wrOpen ? wrId : freeId;
  assign curIdx = wrOpen ? wrCount : '0;
  assign memWr = inValid && 32'(curIdx) < BLOCK_WORDS;
  assign avail = wrCut ? wrCount : slotLen[txId];
  assign txData = mem[MW'(32'(txId) * BLOCK_WORDS + 32'(txIdx))];

  always_comb begin
    next_ring = ring;
    next_head = head;
    next_cnt = cnt;
    next_used = used;
    next_lost = lost;
    next_wrId = wrId;
    next_wrCount = wrCount;
    next_wrOpen = wrOpen;
    next_wrCut = wrCut;
    next_txId = txId;
    next_txIdx = txIdx;
    next_txState = txState;
    next_streaming = streaming;
    next_burstLeft = burstLeft;
    txPush = 1'b0;
    txLast = 1'b0;
    startBlock = 1'b0;
    if (manual && cmdGo) begin
      next_streaming = !multi || burstTotal != '0;
      next_burstLeft = burstTotal;
    end
    if (manual && cmdHalt) begin
      next_streaming = 1'b0;
    end
    unique case (txState)
      TX_IDLE: begin
        if (allowed && cnt != '0) begin
          next_txId = ring[head];
          next_head = stepIdx(head);
          next_cnt = cnt - 1'b1;
          startBlock = 1'b1;
        end else if (allowed && cutOk) begin
          next_txId = wrId;
          next_wrCut = 1'b1;
          startBlock = 1'b1;
        end
        if (startBlock) begin
          next_txIdx = '0;
          next_txState = TX_SEND;
        end
      end
      TX_SEND: begin
        // A stop only clears streaming, so the current block runs to its end.
        if (txIdx < avail && bufSpace) begin
          txPush = 1'b1;
          txLast = !wrCut && txIdx + 1'b1 == avail;
          next_txIdx = txIdx + 1'b1;
          if (txLast) begin
            next_used[txId] = 1'b0;
            next_txState = TX_IDLE;
          end
        end
      end
    endcase
    // A go in the same cycle reloads the count and wins over the burst end.
    if (startBlock && multi && streaming && !cmdGo) begin
      next_burstLeft = burstLeft - 1'b1;
      if (burstLeft <= 32'h00000001) begin
        next_streaming = 1'b0;
      end
    end
    if (inValid) begin
      if (!wrOpen) begin
        next_wrId = freeId;
        next_used[freeId] = 1'b1;
      end
      next_wrCount = curIdx + WW'(memWr);
      next_wrOpen = !inLast;
      if (inLast && (wrCut && wrOpen)) begin
        next_wrCut = 1'b0;
      end else if (inLast) begin
        if (32'(next_cnt) == QUEUE_BLOCKS) begin
          next_used[next_ring[next_head]] = 1'b0;
          next_ring[next_head] = curId;
          next_head = stepIdx(next_head);
          next_lost = lost + 1'b1;
        end else begin
          next_ring[addIdx(next_head, next_cnt)] = curId;
          next_cnt = next_cnt + 1'b1;
        end
      end
    end
    if (cmdFlush) begin
      next_cnt = '0;
      next_head = '0;
      next_txState = TX_IDLE;
      next_wrCut = 1'b0;
      next_used = '0;
      if (next_wrOpen) begin
        next_used[next_wrId] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (memWr) begin
      mem[MW'(32'(curId) * BLOCK_WORDS + 32'(curIdx))] <= inData;
    end
    if (inValid && inLast) begin
      slotLen[curId] <= curIdx + WW'(memWr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ring <= '{default: '0};
      head <= '0;
      cnt <= '0;
      used <= '0;
      lost <= '0;
      wrId <= '0;
      wrCount <= '0;
      wrOpen <= 1'b0;
      wrCut <= 1'b0;
      txId <= '0;
      txIdx <= '0;
      txState <= TX_IDLE;
      streaming <= 1'b0;
      burstLeft <= '0;
    end else begin
      ring <= next_ring;
      head <= next_head;
      cnt <= next_cnt;
      used <= next_used;
      lost <= next_lost;
      wrId <= next_wrId;
      wrCount <= next_wrCount;
      wrOpen <= next_wrOpen;
      wrCut <= next_wrCut;
      txId <= next_txId;
      txIdx <= next_txIdx;
      txState <= next_txState;
      streaming <= next_streaming;
      burstLeft <= next_burstLeft;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer; entry 0 always faces the stream channel.

  logic [DATA_W-1:0] bufData [2];
  logic [DATA_W-1:0] next_bufData [2];
  logic [1:0] bufLast, next_bufLast, bufCnt, next_bufCnt;
  logic pop;

  assign bufSpace = bufCnt != 2'h2;
  assign pop = bufCnt != 2'h0 && outReady;
  assign outValid = bufCnt != 2'h0;
  assign outData = bufData[0];
  assign outLast = bufLast[0];

  always_comb begin
    next_bufData = bufData;
    next_bufLast = bufLast;
    next_bufCnt = bufCnt;
    if (pop) begin
      next_bufData[0] = bufData[1];
      next_bufLast[0] = bufLast[1];
      next_bufCnt = next_bufCnt - 1'b1;
    end
    if (txPush) begin
      next_bufData[next_bufCnt[0]] = txData;
      next_bufLast[next_bufCnt[0]] = txLast;
      next_bufCnt = next_bufCnt + 1'b1;
    end
    if (cmdFlush) begin
      next_bufCnt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bufData <= '{default: '0};
      bufLast <= '0;
      bufCnt <= '0;
    end else begin
      bufData <= next_bufData;
      bufLast <= next_bufLast;
      bufCnt <= next_bufCnt;
    end
  end
endmodule

/* src/transfer_queue_pkg.sv */
// Purpose: Shared constants for the image block transfer queue.
// Assumes: 32-bit APB register bus, one aligned word per register.
// Notes: Offsets are byte addresses.
package transfer_queue_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BURST_OFS = 8'h04;
  localparam logic [7:0] CAP_OFS = 8'h08;
  localparam logic [7:0] OCC_OFS = 8'h0c;
  localparam logic [7:0] LOST_OFS = 8'h10;
  localparam logic [7:0] CMD_OFS = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h18;

  // Control register fields.
  localparam int POLICY_LSB = 0;
  localparam int POLICY_W = 2;
  localparam int SUBMODE_BIT = 2;
  localparam int ORDER_BIT = 3;

  // Command register fields, write-only pulses.
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_HALT_BIT = 1;
  localparam int CMD_FLUSH_BIT = 2;

  // Status register fields.
  localparam int STAT_STREAM_BIT = 0;
  localparam int STAT_SENDING_BIT = 1;

  typedef enum logic [1:0] {
    POLICY_BASIC = 2'h0,
    POLICY_AUTO = 2'h1,
    POLICY_MANUAL = 2'h2
  } send_policy_e;

  typedef enum logic {
    SUBMODE_CONTINUOUS = 1'h0,
    SUBMODE_MULTI = 1'h1
  } manual_send_submode_e;

  // The oldest-first order is the only legal queue policy.
  localparam logic ORDER_OLDEST_FIRST = 1'h0;

  localparam logic [1:0] POLICY_RESET = 2'h0;
  localparam logic SUBMODE_RESET = 1'h0;
  localparam logic [31:0] BURST_RESET = 32'h00000001;
endpackage

/* tb/image_block_transfer_queue_props.sv */
// Purpose: Port-level checks of the image block transfer queue.
// Assumes: Zero-wait APB slave and one clock domain.
// Notes: Bound to every instance of the queue.
`timescale 1ns/1ps
module image_block_transfer_queue_props #(
  parameter int DATA_W = 32,
  parameter int QUEUE_BLOCKS = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [DATA_W-1:0] outData,
  input wire logic outLast
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic cmdWr;
  assign cmdWr = psel && penable && pwrite && paddr == transfer_queue_pkg::CMD_OFS;
  sequence rd_acc(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence stalled;
    outValid && !outReady;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_cap_value: assert property (rd_acc(transfer_queue_pkg::CAP_OFS) |->
    prdata == QUEUE_BLOCKS) else $error("capacity wrong");
  a_occ_bound: assert property (rd_acc(transfer_queue_pkg::OCC_OFS) |->
    prdata <= QUEUE_BLOCKS) else $error("occupancy above capacity");
  a_order_zero: assert property (rd_acc(transfer_queue_pkg::CTRL_OFS) |->
    !prdata[transfer_queue_pkg::ORDER_BIT]) else $error("order bit set");
  a_cmd_reads0: assert property (rd_acc(transfer_queue_pkg::CMD_OFS) |->
    prdata == 32'h0) else $error("command reads nonzero");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h18 |->
    pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && paddr <= 8'h18 && paddr[1:0] == 2'h0 |->
    !pslverr) else $error("mapped access refused");
  a_hold_word: assert property (stalled && !cmdWr |=> outValid && $stable(outData)
    && $stable(outLast)) else $error("stalled word changed");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !outValid && !outLast)
    else $error("output active after reset");
endmodule
bind image_block_transfer_queue image_block_transfer_queue_props #(
  .DATA_W(DATA_W), .QUEUE_BLOCKS(QUEUE_BLOCKS)) props (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .outValid(outValid),
  .outReady(outReady), .outData(outData), .outLast(outLast));

/* tb/stream_sink.sv */
// Purpose: Receiver on the stream channel, prompt or stalling.
// Assumes: Valid and ready handshake, word taken when both are high.
// Notes: Records the first word of every block it receives.
`timescale 1ns/1ps
module stream_sink #(parameter int DATA_W = 32) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic outValid,
  input wire logic [DATA_W-1:0] outData,
  input wire logic outLast,
  output logic outReady
);
  logic [DATA_W-1:0] heads [0:31];
  logic [7:0] nBlocks;
  logic [1:0] phase;
  logic newBlock;
  logic [15:0] wordIdx;
  int badWords;
  always @(posedge ref_clk) begin
    if (reset) begin
      outReady <= 1'b0;
      nBlocks <= 8'h00;
      phase <= 2'h0;
      newBlock <= 1'b1;
      wordIdx <= 16'h0;
      badWords <= 0;
    end else begin
      phase <= phase + 2'h1;
      outReady <= slow ? (phase == 2'h0) : 1'b1;
      if (outValid && outReady) begin
        if (newBlock) heads[nBlocks[4:0]] <= outData;
        newBlock <= outLast;
        if (outData[15:0] !== wordIdx) badWords <= badWords + 1;
        wordIdx <= outLast ? 16'h0 : wordIdx + 16'h1;
        if (outLast) nBlocks <= nBlocks + 8'h01;
      end
    end
  end
endmodule

/* tb/testbench.sv */
// Purpose: Self-checking bench of the image block transfer queue.
// Assumes: Default design parameters, blocks of up to sixteen words.
// Notes: Words carry the block number in the upper half.
`timescale 1ns/1ps
module testbench;
  localparam int QB = 4;
  logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, inData = 32'h0, outData, q;
  logic pready, pslverr, inValid = 1'b0, inLast = 1'b0, outValid, outReady, outLast;
  logic slow = 1'b0, early, err;
  int mismatches = 0, n_compared = 0;
  image_block_transfer_queue dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .inValid(inValid), .inData(inData), .inLast(inLast),
    .outValid(outValid), .outReady(outReady), .outData(outData), .outLast(outLast));
  stream_sink sink (.ref_clk(ref_clk), .reset(reset), .slow(slow), .outValid(outValid),
    .outData(outData), .outLast(outLast), .outReady(outReady));
  initial forever #5 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, e, q);
  endtask
  task automatic send_block(input logic [15:0] id, input int n);
    for (int i = 0; i < n; i++) begin
      inValid <= 1'b1;
      inData <= {id, 16'(i)};
      inLast <= (i == n - 1);
      @(posedge ref_clk);
      if (outValid === 1'b1 && i < n - 1) early = 1'b1;
    end
    inValid <= 1'b0;
    inLast <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wait_blocks(input int n);
    int k;
    k = 0;
    while (sink.nBlocks < n && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    chk("blocks received", n, 32'(sink.nBlocks));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(transfer_queue_pkg::CTRL_OFS, 32'h0, "ctrl reset");
    rd(transfer_queue_pkg::BURST_OFS, 32'h1, "burst reset");
    rd(transfer_queue_pkg::CAP_OFS, QB, "capacity");
    rd(transfer_queue_pkg::OCC_OFS, 32'h0, "occupancy reset");
    rd(transfer_queue_pkg::LOST_OFS, 32'h0, "lost reset");
    rd(transfer_queue_pkg::CMD_OFS, 32'h0, "command reads zero");
    rd(8'h1c, 32'h0, "unmapped data");
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, transfer_queue_pkg::CTRL_OFS, 32'h0000000b);
    rd(transfer_queue_pkg::CTRL_OFS, 32'h0, "illegal policy and order");
    $display("test regs done");
  endtask
  task automatic t_auto();
    early = 1'b0;
    send_block(16'h0, 12);
    chk("sending before block end", 32'h1, {31'h0, early});
    wait_blocks(1);
    apb(1'b1, transfer_queue_pkg::CTRL_OFS, 32'h1);
    slow <= 1'b1;
    for (int b = 1; b < 4; b++) send_block(b[15:0], 8);
    wait_blocks(4);
    for (int b = 1; b < 4; b++) chk("block order", {b[15:0], 16'h0}, sink.heads[b]);
    chk("word order auto", 32'h0, 32'(sink.badWords));
    slow <= 1'b0;
    $display("test auto done");
  endtask
  task automatic t_manual();
    int base;
    base = sink.nBlocks;
    apb(1'b1, transfer_queue_pkg::CTRL_OFS, 32'h2);
    apb(1'b1, transfer_queue_pkg::BURST_OFS, 32'h1);
    for (int b = 0; b < 6; b++) send_block(b[15:0], 8);
    rd(transfer_queue_pkg::OCC_OFS, QB, "occupancy full");
    rd(transfer_queue_pkg::LOST_OFS, 32'h2, "lost tally");
    chk("held before go", base, 32'(sink.nBlocks));
    slow <= 1'b1;
    apb(1'b1, transfer_queue_pkg::CMD_OFS, 32'h1);
    apb(1'b1, transfer_queue_pkg::CMD_OFS, 32'h2);
    rd(transfer_queue_pkg::STAT_OFS, 32'h2, "sending after halt");
    wait_blocks(base + 1);
    repeat (60) @(posedge ref_clk);
    chk("halt after block", base + 1, 32'(sink.nBlocks));
    chk("oldest kept", {16'h2, 16'h0}, sink.heads[base]);
    rd(transfer_queue_pkg::OCC_OFS, 32'h3, "occupancy after halt");
    slow <= 1'b0;
    apb(1'b1, transfer_queue_pkg::CMD_OFS, 32'h1);
    wait_blocks(base + 4);
    apb(1'b1, transfer_queue_pkg::CMD_OFS, 32'h2);
    $display("test manual done");
  endtask
  task automatic t_multi();
    int base;
    base = sink.nBlocks;
    apb(1'b1, transfer_queue_pkg::CTRL_OFS, 32'h6);
    apb(1'b1, transfer_queue_pkg::BURST_OFS, 32'h2);
    for (int b = 8; b < 11; b++) send_block(b[15:0], 8);
    apb(1'b1, transfer_queue_pkg::CMD_OFS, 32'h1);
    wait_blocks(base + 2);
    repeat (60) @(posedge ref_clk);
    chk("burst length", base + 2, 32'(sink.nBlocks));
    rd(transfer_queue_pkg::OCC_OFS, 32'h1, "kept after burst");
    rd(transfer_queue_pkg::STAT_OFS, 32'h0, "stopped after burst");
    apb(1'b1, transfer_queue_pkg::CMD_OFS, 32'h4);
    rd(transfer_queue_pkg::OCC_OFS, 32'h0, "flushed");
    apb(1'b1, transfer_queue_pkg::CTRL_OFS, 32'h1);
    apb(1'b1, transfer_queue_pkg::CMD_OFS, 32'h1);
    rd(transfer_queue_pkg::STAT_OFS, 32'h0, "go ignored in auto");
    chk("word order", 32'h0, 32'(sink.badWords));
    $display("test multi done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_auto();
    t_manual();
    t_multi();
    tally_and_finish();
  end
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule
